// [pkg/hsfs_cfg.svh]
// Purpose: timing counts and encodings for the hot swap fault sequencer
// Assumes: 100 MHz clock
// Notes: long counts are module parameters; these are their defaults
`ifndef HSFS_CFG_SVH
`define HSFS_CFG_SVH
`define HSFS_CLK_MHZ 100
`define HSFS_COOL_S 10
`define HSFS_COOL_CYC (`HSFS_COOL_S * `HSFS_CLK_MHZ * 1000000)
`define HSFS_ATTEMPTS 4'h7
`define HSFS_FILT0_NS 200
`define HSFS_FILT1_NS 900
`define HSFS_FILT2_NS 10700
`define HSFS_FILT3_NS 57000
`define HSFS_NS_TO_CYC(n) (((n) * `HSFS_CLK_MHZ + 999) / 1000)
`endif

// [pkg/hsfs_pkg.sv]
// Purpose: types of the hot swap fault sequencer
// Assumes: nothing
// Notes: threshold select codes map 0..3 to 125, 150, 200, 225 percent
package hsfs_pkg;
   typedef enum {
      ST_RESET, ST_INIT_UP, ST_INIT_DOWN, ST_WAIT_ON, ST_ON, ST_FAULT_UP,
      ST_LATCH_DOWN, ST_RETRY_DOWN, ST_LATCHED, ST_COOL
   } hsfs_state_e;
   typedef enum logic [1:0] {
      RETRY_LATCH, RETRY_SEVEN, RETRY_ENDLESS, RETRY_SEVEN_COOL
   } hsfs_retry_e;
   typedef logic [1:0] hsfs_sel_t;
endpackage

// [design/hsfs_sync.sv]
// Purpose: three-stage synchroniser for asynchronous comparator and pin levels
// Assumes: inputs are slow levels from outside the clock domain
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
module hsfs_sync (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic resetLevel,
   input wire logic din,
   output logic dout
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic next_dout;

   always_comb begin
      next_stage = {stage[1:0], din};
      next_dout = (stage[1] == stage[2]) ? stage[2] : dout;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stage <= 3'b000;
         dout <= 1'b0;
      end else begin
         stage <= next_stage;
         dout <= next_dout;
      end
   end
endmodule

// [design/hsfs_glitch_filter.sv]
// Purpose: severe overcurrent glitch filter with four programmable lengths
// Assumes: severe input already synchronised
// Notes: the event is qualified only after it has stood for the whole window
`timescale 1ns/1ps
`include "hsfs_cfg.svh"
module hsfs_glitch_filter (
   input wire logic clock,
   input wire logic rst_b,
   input wire hsfs_pkg::hsfs_sel_t filterSel,
   input wire logic severe,
   output logic qualified
);
   import hsfs_pkg::*;
   localparam logic [12:0] FILT0 = 13'(`HSFS_NS_TO_CYC(`HSFS_FILT0_NS));
   localparam logic [12:0] FILT1 = 13'(`HSFS_NS_TO_CYC(`HSFS_FILT1_NS));
   localparam logic [12:0] FILT2 = 13'(`HSFS_NS_TO_CYC(`HSFS_FILT2_NS));
   localparam logic [12:0] FILT3 = 13'(`HSFS_NS_TO_CYC(`HSFS_FILT3_NS));
   logic [12:0] count;
   logic [12:0] next_count;
   logic [12:0] limit;
   logic next_qualified;

   always_comb begin
      unique case (filterSel)
         2'h0: limit = FILT0;
         2'h1: limit = FILT1;
         2'h2: limit = FILT2;
         2'h3: limit = FILT3;
      endcase
      next_count = count;
      next_qualified = 1'b0;
      if (!severe) begin
         next_count = 13'h0000;
      end else if (count >= limit - 13'h0001) begin
         next_qualified = 1'b1; // RL15 RL16
      end else begin
         next_count = count + 13'h0001; // RL23
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count <= 13'h0000;
         qualified <= 1'b0;
      end else begin
         count <= next_count;
         qualified <= next_qualified;
      end
   end
endmodule

// [design/hsfs_sequencer.sv]
// Purpose: control sequencer of a negative-supply hot swap controller
// Assumes: analog comparators and current sources sit outside; results arrive
//    as asynchronous levels and controls leave as registered enables
// Notes: cooling periods are parameters so simulation can shorten them
//
// Operation
// RL1: in reset keep gate off and timer discharged.
// RL2: initial cycle charges timer to high, then strong discharge to low.
// RL3: turn on only if no undervoltage or overvoltage after initial cycle.
// RL4: at breaker level enable fault pull-up and current-limit regulation.
// RL5: overcurrent gone before timer high: fault pull-up off, weak pull-down on.
// RL6: overcurrent until timer high: gate off and fault latch low at once.
// RL7: latch-off: weak discharge, latch stays low, no turn-on meanwhile.
// RL8: after timer low, undervoltage toggle or operation on-bit toggle re-enables.
// RL9: latched state clears by power cycle, shutdown, restart, undervoltage, bus.
// RL10: latch strapped to shutdown gives seven attempts then latch-off.
// RL11: latch strapped to restart retries forever, one per ten second cooling.
// RL12: latch to shutdown and alert to restart gives seven per cooling period.
// RL13: retry on time is fault charge, off time weak discharge.
// RL14: severe threshold selectable from four multiples, default one and a half.
// RL15: severe event is glitch filtered by one of four durations.
// RL16: qualified severe event acts within the maximum response time.
// RL17: undervoltage on low input falling; cleared only by high input rising.
// RL18: overvoltage forces gate off through strong pull-down.
// RL19: overvoltage hysteresis source on while the comparator is tripped.
// RL20: shutdown input low keeps gate off, level sensitive.
// RL21: restart falling edge: gate off ten seconds, then power up once.
// RL22: attempt counter clears after ten seconds of continuous power good.
// RL23: inputs synchronised; filter and cooling realised as clock counts.
`timescale 1ns/1ps
`include "hsfs_cfg.svh"
module hsfs_sequencer #(
   parameter int COOL_CYC = `HSFS_COOL_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic supplyOk,
   input wire logic timerHighCmp,
   input wire logic timerLowCmp,
   input wire logic breakerCmp,
   input wire logic severeCmp,
   input wire logic uvLowCmp,
   input wire logic uvHighCmp,
   input wire logic ovCmp,
   input wire logic shutdown_n_input,
   input wire logic restart_n_input,
   input wire logic powerGood,
   input wire hsfs_pkg::hsfs_retry_e retryStrap,
   input wire logic operationOn,
   input wire logic powerCycleCmd,
   input wire hsfs_pkg::hsfs_sel_t severeSel,
   input wire hsfs_pkg::hsfs_sel_t filterSel,
   output logic gateEnable,
   output logic gateRegulate,
   output logic gateStrongOff,
   output logic timerSmallUp,
   output logic timerFaultUp,
   output logic timerWeakDown,
   output logic timerStrongDown,
   output logic latch_n_output,
   output logic second_alert_output_n,
   output logic ovHystEnable,
   output hsfs_pkg::hsfs_sel_t severeThreshold,
   output logic severeFastOff
);
   import hsfs_pkg::*;

   // ---------------------------------------------
   // input synchronisers
   // ---------------------------------------------
   localparam int NSYNC = 11;
   logic [NSYNC-1:0] rawIn;
   logic [NSYNC-1:0] syncIn;
   assign rawIn = {supplyOk, timerHighCmp, timerLowCmp, breakerCmp, severeCmp,
                   uvLowCmp, uvHighCmp, ovCmp, shutdown_n_input, restart_n_input,
                   powerGood};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : gSync
         hsfs_sync uSync ( // RL23
            .clock(clock),
            .rst_b(rst_b),
            .resetLevel(1'b0),
            .din(rawIn[gi]),
            .dout(syncIn[gi])
         );
      end
   endgenerate
   logic sOk, sTimH, sTimL, sBrk, sSev, sUvL, sUvH, sOv, sShdn, sRst, sPg;
   assign {sOk, sTimH, sTimL, sBrk, sSev, sUvL, sUvH, sOv, sShdn, sRst, sPg} = syncIn;

   logic severeQual;
   hsfs_glitch_filter uFilter (
      .clock(clock),
      .rst_b(rst_b),
      .filterSel(filterSel),
      .severe(sSev),
      .qualified(severeQual)
   );

   // ---------------------------------------------
   // sequencer state
   // ---------------------------------------------
   hsfs_state_e state, next_state;
   logic uvFault, next_uvFault;
   logic ovHyst, next_ovHyst;
   logic rstPrev, next_rstPrev;
   logic uvPrev, next_uvPrev;
   logic opPrev, next_opPrev;
   logic opOffSeen, next_opOffSeen;
   logic [3:0] attempts, next_attempts;
   logic [31:0] coolCount, next_coolCount;
   logic [31:0] pgCount, next_pgCount;
   logic alertLow, next_alertLow;
   logic latchLow, next_latchLow;
   logic reenable, restartEdge, clearLatched;

   always_comb begin
      next_state = state;
      next_uvFault = uvFault;
      next_ovHyst = sOv; // RL19
      next_rstPrev = sRst;
      next_uvPrev = uvFault;
      next_opPrev = operationOn;
      next_opOffSeen = opOffSeen;
      next_attempts = attempts;
      next_coolCount = coolCount;
      next_pgCount = pgCount;
      next_alertLow = alertLow;
      next_latchLow = latchLow;
      restartEdge = rstPrev && !sRst; // RL21
      // undervoltage set by low input, cleared only by high input
      if (!sUvL) begin
         next_uvFault = 1'b1; // RL17
      end else if (sUvH) begin
         next_uvFault = 1'b0; // RL17
      end
      if (opPrev && !operationOn) begin
         next_opOffSeen = 1'b1;
      end
      // undervoltage toggle or off-then-on operation re-enables
      reenable = (uvPrev && !uvFault) || (opOffSeen && operationOn && !opPrev); // RL8
      clearLatched = reenable || !sShdn || restartEdge || powerCycleCmd; // RL9
      // attempt counter clears after continuous power good
      if (state == ST_ON && sPg) begin
         if (pgCount >= 32'(COOL_CYC - 1)) begin
            next_attempts = 4'h0; // RL22
         end else begin
            next_pgCount = pgCount + 32'h0000_0001;
         end
      end else begin
         next_pgCount = 32'h0000_0000;
      end
      if (reenable) begin
         next_alertLow = 1'b0;
         next_attempts = 4'h0;
      end
      unique case (state)
         ST_RESET: begin
            if (sOk) next_state = ST_INIT_UP; // RL1
         end
         ST_INIT_UP: begin
            if (sTimH) next_state = ST_INIT_DOWN; // RL2
         end
         ST_INIT_DOWN: begin
            if (sTimL) next_state = ST_WAIT_ON; // RL2
         end
         ST_WAIT_ON: begin
            if (!uvFault && !sOv && sShdn) next_state = ST_ON; // RL3 RL20
         end
         ST_ON: begin
            if (uvFault || sOv || !sShdn) begin
               next_state = ST_WAIT_ON; // RL17 RL18 RL20
            end else if (restartEdge) begin
               next_coolCount = 32'h0000_0000;
               next_state = ST_COOL; // RL21
            end else if (sBrk || severeQual) begin
               next_state = ST_FAULT_UP; // RL4 RL16
            end
         end
         ST_FAULT_UP: begin
            if (uvFault || sOv || !sShdn) begin
               next_state = ST_WAIT_ON;
            end else if (sTimH) begin
               next_latchLow = 1'b1; // RL6
               next_attempts = attempts + 4'h1;
               if (retryStrap == RETRY_LATCH ||
                   ((retryStrap == RETRY_SEVEN) && attempts + 4'h1 >= `HSFS_ATTEMPTS)) begin
                  next_state = ST_LATCH_DOWN; // RL7 RL10
               end else begin
                  next_state = ST_RETRY_DOWN; // RL13
               end
            end else if (!sBrk && !severeQual) begin
               next_state = ST_ON; // RL5
            end
         end
         ST_LATCH_DOWN: begin
            if (sTimL) next_state = ST_LATCHED; // RL7
         end
         ST_RETRY_DOWN: begin
            if (sTimL) begin
               next_latchLow = 1'b0;
               next_coolCount = 32'h0000_0000;
               if (retryStrap == RETRY_ENDLESS) begin
                  next_state = ST_COOL; // RL11
               end else if (retryStrap == RETRY_SEVEN_COOL &&
                            attempts >= `HSFS_ATTEMPTS) begin
                  next_alertLow = 1'b1;
                  next_state = ST_COOL; // RL12
               end else begin
                  next_state = ST_WAIT_ON; // RL10 RL13
               end
            end
         end
         ST_LATCHED: begin
            if (clearLatched) begin
               next_latchLow = 1'b0;
               next_attempts = 4'h0;
               next_state = ST_WAIT_ON; // RL8 RL9
            end
         end
         ST_COOL: begin
            if (coolCount >= 32'(COOL_CYC - 1)) begin
               next_alertLow = 1'b0;
               next_latchLow = 1'b0;
               if (retryStrap == RETRY_SEVEN_COOL) next_attempts = 4'h0;
               next_state = ST_WAIT_ON; // RL11 RL21
            end else begin
               next_coolCount = coolCount + 32'h0000_0001; // RL23
            end
         end
      endcase
      if (!sOk) begin
         next_state = ST_RESET; // RL1
         next_latchLow = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_RESET;
         uvFault <= 1'b1;
         ovHyst <= 1'b0;
         rstPrev <= 1'b0;
         uvPrev <= 1'b1;
         opPrev <= 1'b0;
         opOffSeen <= 1'b0;
         attempts <= 4'h0;
         coolCount <= 32'h0000_0000;
         pgCount <= 32'h0000_0000;
         alertLow <= 1'b0;
         latchLow <= 1'b0;
      end else begin
         state <= next_state;
         uvFault <= next_uvFault;
         ovHyst <= next_ovHyst;
         rstPrev <= next_rstPrev;
         uvPrev <= next_uvPrev;
         opPrev <= next_opPrev;
         opOffSeen <= (next_state == ST_LATCHED) ? next_opOffSeen : 1'b0;
         attempts <= next_attempts;
         coolCount <= next_coolCount;
         pgCount <= next_pgCount;
         alertLow <= next_alertLow;
         latchLow <= next_latchLow;
      end
   end

   // ---------------------------------------------
   // registered outputs: gate, timer and fast-off enables decoded from next state, latch and alert from next flags, ovHystEnable and severeThreshold copied
   // ---------------------------------------------
   logic gateOn;
   assign gateOn = (next_state == ST_ON) || (next_state == ST_FAULT_UP);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         gateEnable <= 1'b0;
         gateRegulate <= 1'b0;
         gateStrongOff <= 1'b1;
         timerSmallUp <= 1'b0;
         timerFaultUp <= 1'b0;
         timerWeakDown <= 1'b0;
         timerStrongDown <= 1'b1;
         latch_n_output <= 1'b1;
         second_alert_output_n <= 1'b1;
         ovHystEnable <= 1'b0;
         severeThreshold <= 2'h1;
         severeFastOff <= 1'b0;
      end else begin
         gateEnable <= gateOn;
         gateRegulate <= (next_state == ST_FAULT_UP); // RL4
         gateStrongOff <= !gateOn || sOv; // RL18 RL1
         timerSmallUp <= (next_state == ST_INIT_UP); // RL2
         timerFaultUp <= (next_state == ST_FAULT_UP); // RL4
         timerWeakDown <= (next_state == ST_ON) || (next_state == ST_LATCH_DOWN) ||
                          (next_state == ST_RETRY_DOWN); // RL5 RL7 RL13
         timerStrongDown <= (next_state == ST_RESET) || (next_state == ST_INIT_DOWN);
         latch_n_output <= !next_latchLow; // RL6 RL7
         second_alert_output_n <= !next_alertLow;
         ovHystEnable <= ovHyst; // RL19
         severeThreshold <= severeSel; // RL14
         severeFastOff <= severeQual && gateOn; // RL16
      end
   end
endmodule

// [test/hsfs_timer_model.sv]
// Purpose: timer capacitor and power-good model facing the sequencer
// Assumes: one charge tick per clock, threshold at TOP ticks
// Notes: rates keep 3:60 up exactly and 3:100 down only roughly
`timescale 1ns/1ps
module hsfs_timer_model #(
   parameter int TOP = 400
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic smallUp,
   input wire logic faultUp,
   input wire logic weakDown,
   input wire logic strongDown,
   input wire logic gateEnable,
   input wire logic gateRegulate,
   output logic timerHighCmp,
   output logic timerLowCmp,
   output logic powerGood
);
   int level;
   int next_level;
   // ----------------------------------------
   // capacitor
   // ----------------------------------------
   always_comb begin
      next_level = level + (smallUp ? 1 : 0) + (faultUp ? 20 : 0);
      next_level = next_level - (weakDown ? 1 : 0) - (strongDown ? 33 : 0);
      if (next_level < 0) next_level = 0;
      if (next_level > TOP + 20) next_level = TOP + 20;
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         level <= 0;
         powerGood <= 1'b0;
      end else begin
         level <= next_level;
         powerGood <= gateEnable & ~gateRegulate;
      end
   end
   assign timerHighCmp = (level >= TOP);
   assign timerLowCmp = (level <= 20);
endmodule

// [test/hsfs_sequencer_sva.sv]
// Purpose: concurrent checks on the sequencer ports
// Assumes: a pin level reaches the outputs within six edges
// Notes: bound from the bench top file
`timescale 1ns/1ps
module hsfs_sequencer_sva (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic timerHighCmp,
   input wire logic timerLowCmp,
   input wire logic breakerCmp,
   input wire logic ovCmp,
   input wire logic shutdown_n_input,
   input wire hsfs_pkg::hsfs_retry_e retryStrap,
   input wire hsfs_pkg::hsfs_sel_t severeSel,
   input wire logic gateEnable,
   input wire logic gateRegulate,
   input wire logic gateStrongOff,
   input wire logic timerSmallUp,
   input wire logic timerFaultUp,
   input wire logic timerWeakDown,
   input wire logic timerStrongDown,
   input wire logic latch_n_output,
   input wire logic ovHystEnable,
   input wire hsfs_pkg::hsfs_sel_t severeThreshold
);
   import hsfs_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence s_ovHeld;
      ovCmp [*6];
   endsequence
   sequence s_faultTrip;
      $rose(timerHighCmp) && timerFaultUp;
   endsequence
   property p_rstHold;
      !$past(rst_b) |-> !gateEnable && timerStrongDown && latch_n_output;
   endproperty
   property p_initTurn;
      $rose(timerHighCmp) && timerSmallUp |-> ##[1:6] timerStrongDown && !timerSmallUp;
   endproperty
   property p_breaker;
      $rose(breakerCmp) && gateEnable |-> ##[1:6] timerFaultUp && gateRegulate;
   endproperty
   property p_glitch;
      $fell(breakerCmp) && timerFaultUp && !timerHighCmp
         |-> ##[1:6] !timerFaultUp && timerWeakDown;
   endproperty
   property p_trip;
      s_faultTrip |-> ##[1:6] !latch_n_output && !gateEnable;
   endproperty
   property p_latchOff;
      retryStrap == RETRY_LATCH && !latch_n_output && !timerLowCmp |-> !gateEnable;
   endproperty
   property p_ovOff;
      s_ovHeld |-> !gateEnable && gateStrongOff;
   endproperty
   // the hysteresis enable sits two registers behind the synchronised level
   property p_ovHyst;
      s_ovHeld ##1 ovCmp |-> ovHystEnable;
   endproperty
   property p_shutdown_n_input;
      !shutdown_n_input [*6] |-> !gateEnable;
   endproperty
   property p_sevSel;
      $stable(severeSel) [*6] |-> severeThreshold == severeSel;
   endproperty
   a_rstHold: assert property (p_rstHold) else $error("reset outputs");
   a_initTurn: assert property (p_initTurn) else $error("initial discharge");
   a_breaker: assert property (p_breaker) else $error("breaker response");
   a_glitch: assert property (p_glitch) else $error("glitch recovery");
   a_trip: assert property (p_trip) else $error("timer trip");
   a_latchOff: assert property (p_latchOff) else $error("on while latched");
   a_ovOff: assert property (p_ovOff) else $error("ov gate");
   a_ovHyst: assert property (p_ovHyst) else $error("ov hysteresis");
   a_shutdown_n_input: assert property (p_shutdown_n_input) else $error("shutdown gate");
   a_sevSel: assert property (p_sevSel) else $error("severe select");
endmodule

// [test/hsfs_sequencer_tb.sv]
// Purpose: self-checking bench of the hot swap fault sequencer
// Assumes: cooling shortened to 50 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module hsfs_sequencer_tb;
   import hsfs_pkg::*;
   logic clock = 0, rst_b = 0, supplyOk = 0, breakerCmp = 0, uv = 0, ovCmp = 0;
   logic shdnN = 1, restartN = 1, opOn = 1, pcCmd = 0, severeCmp = 0;
   hsfs_retry_e strap = RETRY_LATCH;
   hsfs_sel_t sevSel = 2'h1, filtSel = 2'h0, sevThr;
   logic tHi, tLo, pg, gateEnable, gateRegulate, gateStrongOff, tSmall, tFault;
   logic tWeak, tStrong, latchN, alertN, ovHyst, fastOff;
   int fail_count = 0, compares = 0;
   always #5 clock = ~clock;
   hsfs_sequencer #(.COOL_CYC(50)) hsfs_sequencer_i (.clock(clock), .rst_b(rst_b),
      .supplyOk(supplyOk), .timerHighCmp(tHi), .timerLowCmp(tLo),
      .breakerCmp(breakerCmp), .severeCmp(severeCmp), .uvLowCmp(uv), .uvHighCmp(uv),
      .ovCmp(ovCmp), .shutdown_n_input(shdnN), .restart_n_input(restartN),
      .powerGood(pg), .retryStrap(strap), .operationOn(opOn), .powerCycleCmd(pcCmd),
      .severeSel(sevSel), .filterSel(filtSel), .gateEnable(gateEnable),
      .gateRegulate(gateRegulate), .gateStrongOff(gateStrongOff), .timerSmallUp(tSmall),
      .timerFaultUp(tFault), .timerWeakDown(tWeak), .timerStrongDown(tStrong),
      .latch_n_output(latchN), .second_alert_output_n(alertN), .ovHystEnable(ovHyst),
      .severeThreshold(sevThr), .severeFastOff(fastOff));
   hsfs_timer_model hsfs_timer_model_i (.clock(clock), .rst_b(rst_b), .smallUp(tSmall),
      .faultUp(tFault), .weakDown(tWeak), .strongDown(tStrong), .gateEnable(gateEnable),
      .gateRegulate(gateRegulate), .timerHighCmp(tHi), .timerLowCmp(tLo), .powerGood(pg));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic till(ref logic s, input logic v);
      for (int i = 0; i < 3000 && s !== v; i++) cyc(1);
      if (s !== v) begin
         fail_count++;
         $display("[ERR] %0t wait timed out", $time);
      end
   endtask
   task automatic chk(input logic a, input logic e, input string m);
      compares++;
      if (a !== e) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic chkv(input logic [3:0] a, input logic [3:0] e, input string m);
      compares++;
      if (a !== e) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic results;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_power;
      supplyOk = 1;
      till(tSmall, 1);
      chk(tSmall, 1, "no initial charge");
      till(tHi, 1);
      till(tLo, 1);
      cyc(20);
      chk(gateEnable, 0, "on under uv");
      uv = 1;
      till(gateEnable, 1);
      chk(gateEnable, 1, "no turn on");
      $display("t_power done");
   endtask
   task automatic t_short;
      breakerCmp = 1;
      till(tFault, 1);
      chk(gateRegulate, 1, "no regulation");
      breakerCmp = 0;
      till(tFault, 0);
      chk(tWeak, 1, "no weak discharge");
      chk(latchN, 1, "latched on glitch");
      till(tLo, 1);
      cyc(10);
      $display("t_short done");
   endtask
   task automatic t_latch;
      breakerCmp = 1;
      till(latchN, 0);
      chk(gateEnable, 0, "gate on after trip");
      breakerCmp = 0;
      cyc(100);
      chk(tWeak, 1, "no weak discharge");
      chk(gateEnable, 0, "on while discharging");
      till(tLo, 1);
      cyc(20);
      chk(latchN, 0, "latch released");
      opOn = 0;
      cyc(10);
      opOn = 1;
      till(gateEnable, 1);
      chk(latchN, 1, "toggle ignored");
      $display("t_latch done");
   endtask
   task automatic t_ov;
      ovCmp = 1;
      cyc(8);
      chk(gateEnable, 0, "ov gate on");
      chk(gateStrongOff, 1, "ov weak off");
      chk(ovHyst, 1, "no hysteresis");
      ovCmp = 0;
      cyc(8);
      chk(ovHyst, 0, "hysteresis stays");
      till(gateEnable, 1);
      $display("t_ov done");
   endtask
   task automatic t_shutdown_n_input;
      shdnN = 0;
      cyc(40);
      chk(gateEnable, 0, "on in shutdown");
      shdnN = 1;
      till(gateEnable, 1);
      chk(gateEnable, 1, "no return");
      $display("t_shutdown_n_input done");
   endtask
   task automatic t_sev;
      for (int k = 0; k < 4; k++) begin
         sevSel = k[1:0];
         cyc(8);
         chkv({2'h0, sevThr}, k[3:0], "severe threshold");
      end
      sevSel = 2'h1;
      $display("t_sev done");
   endtask
   task automatic t_seven;
      logic [3:0] n;
      logic p;
      n = 4'h0;
      p = 1'b0;
      cyc(100);
      strap = RETRY_SEVEN;
      breakerCmp = 1;
      repeat (6000) begin
         cyc(1);
         if (tFault && !p) n++;
         p = tFault;
      end
      chkv(n, 4'h7, "attempt count");
      chk(gateEnable, 0, "on after seven");
      breakerCmp = 0;
      uv = 0;
      cyc(10);
      uv = 1;
      till(gateEnable, 1);
      chk(gateEnable, 1, "uv toggle ignored");
      $display("t_seven done");
   endtask
   task automatic t_restart;
      restartN = 0;
      cyc(8);
      chk(gateEnable, 0, "restart gate on");
      cyc(40);
      chk(gateEnable, 0, "cooling short");
      till(gateEnable, 1);
      cyc(100);
      chk(gateEnable, 1, "held restart repeats");
      restartN = 1;
      cyc(8);
      $display("t_restart done");
   endtask
   task automatic t_severe;
      int n;
      severeCmp = 1;
      cyc(10);
      severeCmp = 0;
      cyc(10);
      chk(tFault, 0, "glitch passed");
      chk(fastOff, 0, "glitch fast off");
      severeCmp = 1;
      n = 0;
      while (fastOff !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk(n >= 20, 1, "severe filter short");
      chk(n <= 30, 1, "severe response slow");
      chk(tFault, 1, "severe no fault timer");
      severeCmp = 0;
      till(tFault, 0);
      chk(fastOff, 0, "fast off stuck");
      $display("t_severe done");
   endtask
   task automatic t_cool;
      logic [3:0] n;
      logic p;
      n = 4'h0;
      p = 1'b0;
      strap = RETRY_SEVEN_COOL;
      breakerCmp = 1;
      for (int i = 0; i < 4000 && alertN === 1'b1; i++) begin
         cyc(1);
         if (tFault && !p) n++;
         p = tFault;
      end
      chkv(n, 4'h7, "attempts per cooling");
      chk(alertN, 0, "no alert after seven");
      chk(gateEnable, 0, "on while cooling");
      breakerCmp = 0;
      till(gateEnable, 1);
      chk(alertN, 1, "alert not cleared");
      strap = RETRY_ENDLESS;
      breakerCmp = 1;
      till(latchN, 0);
      till(latchN, 1);
      cyc(20);
      chk(gateEnable, 0, "on in endless cooling");
      till(tFault, 1);
      chk(latchN, 1, "endless retry latched");
      breakerCmp = 0;
      till(tFault, 0);
      $display("t_cool done");
   endtask
   initial begin
      cyc(6);
      chk(gateEnable, 0, "gate in reset");
      chk(tStrong, 1, "timer in reset");
      rst_b = 1;
      t_power;
      t_short;
      t_latch;
      t_ov;
      t_shutdown_n_input;
      t_restart;
      t_sev;
      t_severe;
      t_seven;
      t_cool;
      results;
   end
   initial begin
      #300000;
      fail_count++;
      $display("[ERR] %0t watchdog", $time);
      results;
   end
endmodule
bind hsfs_sequencer hsfs_sequencer_sva hsfs_sequencer_sva_i (.*);
